// >>> include/pllc_pkg.sv
// Purpose: Shared constants for the PLL lock detect and VCO calibration control block.
// Assumes: 32-bit APB register words, 20 MHz control clock.
// Notes:   Timing figures are kept in their printed units, cycle counts derive from them.
package pllc_pkg;

    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_PS   = 50000;
    localparam int LOCK_WIN0_PS    = 2100;
    localparam int LOCK_WIN1_PS    = 4600;
    localparam int LOCK_WIN2_PS    = 7200;
    localparam int LOCK_WIN3_PS    = 19900;
    // A window is a longest time, so it rounds down, but never below one cycle.
    localparam int LOCK_WIN0_CYC   = (LOCK_WIN0_PS / CLK_PERIOD_PS < 1) ? 1 : LOCK_WIN0_PS / CLK_PERIOD_PS;
    localparam int LOCK_WIN1_CYC   = (LOCK_WIN1_PS / CLK_PERIOD_PS < 1) ? 1 : LOCK_WIN1_PS / CLK_PERIOD_PS;
    localparam int LOCK_WIN2_CYC   = (LOCK_WIN2_PS / CLK_PERIOD_PS < 1) ? 1 : LOCK_WIN2_PS / CLK_PERIOD_PS;
    localparam int LOCK_WIN3_CYC   = (LOCK_WIN3_PS / CLK_PERIOD_PS < 1) ? 1 : LOCK_WIN3_PS / CLK_PERIOD_PS;
    localparam int SETTLE_PERIODS  = 16384;
    localparam int CAL_PERIODS     = 550;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0]  REG0_ADDR      = 8'h00;
    localparam logic [7:0]  REG2_ADDR      = 8'h08;
    localparam logic [7:0]  STAT_ADDR      = 8'h10;
    localparam logic [31:0] REG0_RST       = 32'h0000_0008;
    localparam logic [31:0] REG2_RST       = 32'h0000_0080;
    localparam int          LOCK_QUAL_LSB  = 0;
    localparam int          LOCK_QUAL_W    = 8;
    localparam int          LOCK_WINDOW_SELECT_HI_BIT   = 13;
    localparam int          LOCK_WINDOW_SELECT_LO_BIT   = 14;
    localparam int          LOCK_STAT_BIT  = 6;
    localparam int          PDN_BIT        = 7;
    localparam int          CAL_SEL_BIT    = 13;
    localparam int          LOOP_RST_BIT   = 20;
    localparam int          ST_CAL_BIT     = 0;
    localparam int          ST_REF_BIT     = 1;
    localparam int          ST_OUTEN_BIT   = 2;
    localparam int          ST_LOCK_BIT    = 3;

    // ------------------------------------------------------------------
    // Input synchroniser lanes
    // ------------------------------------------------------------------
    localparam int          SY_IN_DIV      = 0;
    localparam int          SY_FB_DIV      = 1;
    localparam int          SY_REF_OK      = 2;
    localparam int          SY_PD_PIN      = 3;
    localparam logic [3:0]  SYNC_RST       = 4'h8;

    typedef enum logic [2:0] {
        ST_REQ, ST_LOAD, ST_WREF, ST_SETTLE, ST_CAL, ST_RUN, ST_PWRDN, ST_PINDN
    } pllc_state_e;

endpackage

// >>> core/pllc_ctrl.sv
// Purpose: Lock detector and VCO calibration sequencer of a clock synthesizer PLL.
// Assumes: Divider outputs, reference-present and power-down pin are asynchronous.
// Notes:   Registers sit on APB; the input divider clock also serves as PFD clock.
//
// Operation
// - Lock shown on pin and register bit.
// - Locked when phase error within window.
// - Input divider is the phase reference.
// - Window select picks one of four widths; at the 20 MHz clock all four round down to one cycle here.
// - One bad cycle or slip drops lock.
// - Many successive good cycles qualify lock.
// - Auto calibration after load and clock.
// - Without reference, calibration waits for it.
// - Loop reset rise starts calibration when selected.
// - Outputs off during loop reset calibration.
// - Power-down bit low disables all outputs; here only while the calibration select bit is low.
// - Power-down release calibrates, then outputs on.
// - Pin pulse reloads, clears select, calibrates.
// - Settle 16384 input periods after reset.
// - Calibration lasts 550 phase-detector periods.
//
// Decided for this implementation: the address map and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none

module pllc_ctrl #(
    parameter int SETTLE_CYC = pllc_pkg::SETTLE_PERIODS
) (
    input  wire logic        REF_CLK_I,
    input  wire logic        RESETN_I,
    input  wire logic [7:0]  PADDR_I,
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [31:0] PWDATA_I,
    output logic      [31:0] PRDATA_O,
    output logic             PREADY_O,
    output logic             PSLVERR_O,
    input  wire logic        IN_DIV_CLK_I,
    input  wire logic        FB_DIV_CLK_I,
    input  wire logic        REF_PRESENT_I,
    input  wire logic        PD_PIN_N_I,
    input  wire logic        NVM_DONE_I,
    input  wire logic [31:0] NVM_REG0_I,
    input  wire logic [31:0] NVM_REG2_I,
    output logic             NVM_RELOAD_O,
    output logic             PLL_LOCK_O,
    output logic             CLK_OUT_EN_O,
    output logic             CAL_BUSY_O
);
    import pllc_pkg::*;

    function automatic logic [7:0] win_cycles(input logic [1:0] sel);
        case (sel)
            2'b00:   win_cycles = 8'(LOCK_WIN0_CYC);
            2'b01:   win_cycles = 8'(LOCK_WIN1_CYC);
            2'b10:   win_cycles = 8'(LOCK_WIN2_CYC);
            default: win_cycles = 8'(LOCK_WIN3_CYC);
        endcase
    endfunction

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    logic [3:0] s1_r, s2_r, s3_r;
    logic [3:0] rise, fall;

    always_ff @(posedge REF_CLK_I) begin
        if (!RESETN_I) begin
            s1_r <= SYNC_RST;
            s2_r <= SYNC_RST;
            s3_r <= SYNC_RST;
        end else begin
            s1_r <= {PD_PIN_N_I, REF_PRESENT_I, FB_DIV_CLK_I, IN_DIV_CLK_I};
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    assign rise = s2_r & ~s3_r;
    assign fall = ~s2_r & s3_r;

    // ------------------------------------------------------------------
    // Register file and APB slave
    // ------------------------------------------------------------------
    logic [31:0] reg0_r, reg0_nxt;
    logic [31:0] reg2_r, reg2_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    pllc_state_e state_r, state_nxt;
    logic        boot_r, lock_r, cal_r, outen_r;
    logic        mapped, wr_acc;

    assign mapped    = (PADDR_I == REG0_ADDR) || (PADDR_I == REG2_ADDR) || (PADDR_I == STAT_ADDR);
    assign wr_acc    = PSEL_I && PENABLE_I && PWRITE_I;
    assign PREADY_O  = 1'b1;
    assign PSLVERR_O = PSEL_I && PENABLE_I && !mapped;
    assign PRDATA_O  = rdata_r;

    always_comb begin
        reg0_nxt  = reg0_r;
        reg2_nxt  = reg2_r;
        rdata_nxt = rdata_r;
        if (NVM_DONE_I && state_r == ST_LOAD) begin
            reg0_nxt = NVM_REG0_I;
            reg2_nxt = NVM_REG2_I;
            if (!boot_r) begin
                reg2_nxt[CAL_SEL_BIT] = 1'b0;
            end
        end else if (wr_acc && PADDR_I == REG0_ADDR) begin
            reg0_nxt = PWDATA_I;
        end else if (wr_acc && PADDR_I == REG2_ADDR) begin
            reg2_nxt = PWDATA_I;
        end
        // The lock bit is never stored; reads always mirror the detector.
        reg2_nxt[LOCK_STAT_BIT] = 1'b0;
        if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
            rdata_nxt = 32'h0000_0000;
            if (PADDR_I == REG0_ADDR) begin
                rdata_nxt = reg0_r;
            end else if (PADDR_I == REG2_ADDR) begin
                rdata_nxt = reg2_r;
                rdata_nxt[LOCK_STAT_BIT] = lock_r;
            end else if (PADDR_I == STAT_ADDR) begin
                rdata_nxt[ST_CAL_BIT]   = cal_r;
                rdata_nxt[ST_REF_BIT]   = s2_r[SY_REF_OK];
                rdata_nxt[ST_OUTEN_BIT] = outen_r;
                rdata_nxt[ST_LOCK_BIT]  = lock_r;
            end
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (!RESETN_I) begin
            reg0_r  <= REG0_RST;
            reg2_r  <= REG2_RST;
            rdata_r <= 32'h0000_0000;
        end else begin
            reg0_r  <= reg0_nxt;
            reg2_r  <= reg2_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Calibration sequencer
    // ------------------------------------------------------------------
    logic [15:0] cnt_r, cnt_nxt;
    logic        boot_nxt, lr_q_r, pdn_q_r;
    logic        in_edge, pdn, sel;

    assign in_edge = rise[SY_IN_DIV];
    assign pdn     = reg2_r[PDN_BIT];
    assign sel     = reg2_r[CAL_SEL_BIT];

    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        boot_nxt  = boot_r;
        if (fall[SY_PD_PIN] && state_r != ST_PINDN) begin
            state_nxt = ST_PINDN;
        end else begin
            unique case (state_r)
                ST_REQ: begin
                    state_nxt = ST_LOAD;
                end
                ST_LOAD: begin
                    if (NVM_DONE_I) begin
                        state_nxt = ST_WREF;
                    end
                end
                ST_WREF: begin
                    cnt_nxt = 16'h0000;
                    if (s2_r[SY_REF_OK]) begin
                        state_nxt = boot_r ? ST_SETTLE : ST_CAL;
                    end
                end
                ST_SETTLE: begin
                    if (in_edge) begin
                        cnt_nxt = cnt_r + 16'h0001;
                        if (cnt_r == 16'(SETTLE_CYC - 1)) begin
                            state_nxt = ST_CAL;
                            cnt_nxt   = 16'h0000;
                            boot_nxt  = 1'b0;
                        end
                    end
                end
                ST_CAL: begin
                    if (in_edge) begin
                        cnt_nxt = cnt_r + 16'h0001;
                        if (cnt_r == 16'(CAL_PERIODS - 1)) begin
                            state_nxt = ST_RUN;
                            cnt_nxt   = 16'h0000;
                        end
                    end
                end
                ST_RUN: begin
                    cnt_nxt = 16'h0000;
                    if (sel && pdn && reg2_r[LOOP_RST_BIT] && !lr_q_r) begin
                        state_nxt = ST_CAL;
                    end else if (!sel && !pdn && pdn_q_r) begin
                        state_nxt = ST_PWRDN;
                    end
                end
                ST_PWRDN: begin
                    cnt_nxt = 16'h0000;
                    if (pdn) begin
                        state_nxt = ST_CAL;
                    end
                end
                ST_PINDN: begin
                    if (rise[SY_PD_PIN]) begin
                        state_nxt = ST_REQ;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (!RESETN_I) begin
            state_r      <= ST_REQ;
            cnt_r        <= 16'h0000;
            boot_r       <= 1'b1;
            lr_q_r       <= 1'b0;
            pdn_q_r      <= 1'b1;
            outen_r      <= 1'b0;
            cal_r        <= 1'b0;
            NVM_RELOAD_O <= 1'b0;
        end else begin
            state_r      <= state_nxt;
            cnt_r        <= cnt_nxt;
            boot_r       <= boot_nxt;
            lr_q_r       <= reg2_r[LOOP_RST_BIT];
            pdn_q_r      <= pdn;
            outen_r      <= (state_nxt == ST_RUN);
            cal_r        <= (state_nxt == ST_CAL);
            // Taken from the present state so the pulse follows reset as well as the pin.
            NVM_RELOAD_O <= (state_r == ST_REQ);
        end
    end

    assign CLK_OUT_EN_O = outen_r;
    assign CAL_BUSY_O   = cal_r;

    // ------------------------------------------------------------------
    // Phase lock detector
    // ------------------------------------------------------------------
    logic [7:0] since_ref_r, since_ref_nxt;
    logic [7:0] since_fb_r, since_fb_nxt;
    logic [7:0] good_r, good_nxt;
    logic       pend_r, pend_nxt, fb_seen_r, fb_seen_nxt;
    logic       ref_seen_r, ref_seen_nxt, lock_nxt;
    logic [7:0] win, qual;
    logic       re, fe, good, bad, slip;

    assign re   = rise[SY_IN_DIV];
    assign fe   = rise[SY_FB_DIV];
    assign win  = win_cycles({reg0_r[LOCK_WINDOW_SELECT_HI_BIT], reg0_r[LOCK_WINDOW_SELECT_LO_BIT]});
    assign qual = reg0_r[LOCK_QUAL_LSB +: LOCK_QUAL_W];
    // A feedback edge on the reference edge belongs to the new cycle, so it is no slip.
    assign slip = (re && ref_seen_r && !fb_seen_r) || (fe && !re && fb_seen_r);

    always_comb begin
        good          = 1'b0;
        bad           = 1'b0;
        pend_nxt      = pend_r;
        since_ref_nxt = (since_ref_r == 8'hFF) ? since_ref_r : since_ref_r + 8'h01;
        since_fb_nxt  = (since_fb_r == 8'hFF) ? since_fb_r : since_fb_r + 8'h01;
        fb_seen_nxt   = fb_seen_r | fe;
        ref_seen_nxt  = ref_seen_r | re;
        if (re) begin
            since_ref_nxt = 8'h00;
            fb_seen_nxt   = fe;
            bad           = pend_r;
            // Difference in cycles is one more than the age counter.
            if (fe || (since_fb_r < win - 8'h01)) begin
                good     = !pend_r;
                pend_nxt = 1'b0;
            end else begin
                pend_nxt = 1'b1;
            end
        end else if (pend_r) begin
            if (fe && (since_ref_r < win - 8'h01)) begin
                good     = 1'b1;
                pend_nxt = 1'b0;
            end else if (since_ref_r >= win - 8'h01) begin
                bad      = 1'b1;
                pend_nxt = 1'b0;
            end
        end
        if (fe) begin
            since_fb_nxt = 8'h00;
        end
        lock_nxt = lock_r;
        good_nxt = good_r;
        if (state_nxt != ST_RUN || !pdn) begin
            lock_nxt     = 1'b0;
            good_nxt     = 8'h00;
            pend_nxt     = 1'b0;
            ref_seen_nxt = 1'b0;
        end else if (bad || slip) begin
            lock_nxt = 1'b0;
            good_nxt = 8'h00;
        end else if (good) begin
            good_nxt = (good_r == 8'hFF) ? good_r : good_r + 8'h01;
            if (good_r + 8'h01 >= qual) begin
                lock_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (!RESETN_I) begin
            since_ref_r <= 8'hFF;
            since_fb_r  <= 8'hFF;
            good_r      <= 8'h00;
            pend_r      <= 1'b0;
            fb_seen_r   <= 1'b0;
            ref_seen_r  <= 1'b0;
            lock_r      <= 1'b0;
        end else begin
            since_ref_r <= since_ref_nxt;
            since_fb_r  <= since_fb_nxt;
            good_r      <= good_nxt;
            pend_r      <= pend_nxt;
            fb_seen_r   <= fb_seen_nxt;
            ref_seen_r  <= ref_seen_nxt;
            lock_r      <= lock_nxt;
        end
    end

    assign PLL_LOCK_O = lock_r;

endmodule

`default_nettype wire

// >>> sim/pllc_ctrl_props.sv
// Purpose: Port-level properties of the PLL lock and calibration control.
// Assumes: One clock domain with a synchronous active-low reset.
// Notes:   Bound to the design from the bench top file.
`timescale 1ns/100ps
`default_nettype none

module pllc_ctrl_props
    import pllc_pkg::*;
#(
    parameter int SETTLE_CYC = 8
) (
    input wire logic        REF_CLK_I,
    input wire logic        RESETN_I,
    input wire logic [7:0]  PADDR_I,
    input wire logic        PSEL_I,
    input wire logic        PENABLE_I,
    input wire logic        PWRITE_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic [31:0] PRDATA_O,
    input wire logic        PREADY_O,
    input wire logic        PSLVERR_O,
    input wire logic        IN_DIV_CLK_I,
    input wire logic        FB_DIV_CLK_I,
    input wire logic        REF_PRESENT_I,
    input wire logic        PD_PIN_N_I,
    input wire logic        NVM_DONE_I,
    input wire logic [31:0] NVM_REG0_I,
    input wire logic [31:0] NVM_REG2_I,
    input wire logic        NVM_RELOAD_O,
    input wire logic        PLL_LOCK_O,
    input wire logic        CLK_OUT_EN_O,
    input wire logic        CAL_BUSY_O
);
    // ----------------
    // Helper logic
    // ----------------
    logic [11:0] busy_cnt_r;
    logic [11:0] busy_cnt_nxt;
    logic        rd_reg2;
    logic        wr_pd_off;

    assign rd_reg2   = PSEL_I && PENABLE_I && !PWRITE_I && (PADDR_I == REG2_ADDR);
    assign wr_pd_off = PSEL_I && PENABLE_I && PWRITE_I && (PADDR_I == REG2_ADDR)
                       && !PWDATA_I[PDN_BIT] && !PWDATA_I[CAL_SEL_BIT];

    always_comb begin
        busy_cnt_nxt = (RESETN_I && CAL_BUSY_O) ? busy_cnt_r + 12'h001 : 12'h000;
    end

    always_ff @(posedge REF_CLK_I) begin
        busy_cnt_r <= busy_cnt_nxt;
    end

    // ----------------
    // Properties
    // ----------------
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (!RESETN_I);

    chk_lock_bit_pin: assert property (
        rd_reg2 && $stable(PLL_LOCK_O) |-> PRDATA_O[LOCK_STAT_BIT] == PLL_LOCK_O)
        else $error("lock bit and pin differ");
    chk_cal_outputs_off: assert property (
        CAL_BUSY_O |-> !CLK_OUT_EN_O && !PLL_LOCK_O)
        else $error("output or lock during calibration");
    chk_lock_needs_en: assert property (
        PLL_LOCK_O |-> CLK_OUT_EN_O)
        else $error("lock while outputs off");
    chk_cal_min_len: assert property (
        $fell(CAL_BUSY_O) |-> busy_cnt_r >= 12'h226)
        else $error("calibration too short");
    chk_en_after_cal: assert property (
        $fell(CAL_BUSY_O) && PD_PIN_N_I && $past(PD_PIN_N_I, 4) |-> CLK_OUT_EN_O)
        else $error("outputs not on after calibration");
    chk_reload_after_rst: assert property (
        $rose(RESETN_I) |-> ##[0:2] NVM_RELOAD_O)
        else $error("no reload after reset");
    chk_reload_one_cyc: assert property (
        NVM_RELOAD_O |=> !NVM_RELOAD_O)
        else $error("reload pulse too long");
    chk_cal_waits_ref: assert property (
        $rose(CAL_BUSY_O) |-> $past(REF_PRESENT_I, 2))
        else $error("calibration without reference");
    chk_pd_write_off: assert property (
        wr_pd_off |-> ##[1:3] (!CLK_OUT_EN_O) [*4])
        else $error("outputs on in power down");

    cover property ($rose(PLL_LOCK_O));
    cover property ($fell(CAL_BUSY_O) ##1 CLK_OUT_EN_O);
    cover property (PSLVERR_O);
endmodule
`default_nettype wire

// >>> sim/pllc_ctrl_tb.sv
// Purpose: Self-checking bench for the PLL lock and calibration control.
// Assumes: Divider outputs are a 4-cycle square wave made from the bench clock.
// Notes:   The settle count is shortened so the run stays brief.
`timescale 1ns/100ps
`default_nettype none

module pllc_ctrl_tb;
    import pllc_pkg::*;

    localparam int SETTLE = 8;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic        in_div = 1'b0;
    logic        fb_div = 1'b0;
    logic        fb_skew = 1'b0;
    logic [1:0]  ph = 2'h0;
    logic        ref_ok = 1'b0;
    logic        pd_pin_n = 1'b1;
    logic        nvm_done = 1'b0;
    logic [31:0] nvm0 = 32'h0;
    logic [31:0] nvm2 = 32'h0;
    logic [31:0] prdata, rdv;
    logic        pready, pslverr, reload, lock, out_en, busy, err;
    int          fails = 0;
    int          check_count = 0;

    pllc_ctrl #(.SETTLE_CYC(SETTLE)) pllc_ctrl_i (
        .REF_CLK_I(clk), .RESETN_I(rst_n), .PADDR_I(paddr), .PSEL_I(psel),
        .PENABLE_I(penable), .PWRITE_I(pwrite), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .IN_DIV_CLK_I(in_div),
        .FB_DIV_CLK_I(fb_div), .REF_PRESENT_I(ref_ok), .PD_PIN_N_I(pd_pin_n),
        .NVM_DONE_I(nvm_done), .NVM_REG0_I(nvm0), .NVM_REG2_I(nvm2),
        .NVM_RELOAD_O(reload), .PLL_LOCK_O(lock), .CLK_OUT_EN_O(out_en), .CAL_BUSY_O(busy));

    initial begin
        forever #25 clk = ~clk;
    end

    // A skew of half a divider period puts every feedback edge outside the window.
    always @(posedge clk) begin
        ph     <= ph + 2'h1;
        in_div <= ~ph[1];
        fb_div <= ~(ph[1] ^ fb_skew);
    end

    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] got);
        check_count++;
        if (got !== x) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, x, got);
        end
    endtask

    task automatic apb(input logic we, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rdo, output logic e);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= we;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        rdo = prdata;
        e   = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rdv, err);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0, rdv, err);
        chk($sformatf("reg_%h", a), x, rdv);
    endtask

    task automatic wait_reload();
        int n;
        n = 0;
        while (reload !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        chk("reload", 32'h1, {31'h0, reload});
    endtask

    task automatic nvm_pulse(input logic [31:0] r0, input logic [31:0] r2);
        @(posedge clk);
        nvm0     <= r0;
        nvm2     <= r2;
        nvm_done <= 1'b1;
        @(posedge clk);
        nvm_done <= 1'b0;
    endtask

    task automatic cal_cycle(input int lo, input int hi);
        int pre;
        int len;
        pre = 0;
        len = 0;
        while (busy !== 1'b1 && pre < 400) begin
            @(negedge clk);
            pre++;
        end
        chk("cal_start", 32'h1, {31'h0, (pre >= lo && pre <= hi)});
        while (busy === 1'b1 && len < 3000) begin
            @(negedge clk);
            len++;
        end
        chk("cal_len", 32'h1, {31'h0, (len >= 2196 && len <= 2204)});
        chk("out_en", 32'h1, {31'h0, out_en});
    endtask

    task automatic lock_wait(input logic v, input int lo, input int hi);
        int n;
        n = 0;
        while (lock !== v && n < 300) begin
            @(negedge clk);
            n++;
        end
        chk("lock_delay", 32'h1, {31'h0, (n >= lo && n <= hi)});
    endtask

    task automatic finish_test();
        if (fails == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge clk);
        fails++;
        finish_test();
    end

    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        wait_reload();
        rd(REG0_ADDR, REG0_RST);
        rd(REG2_ADDR, REG2_RST);
        rd(STAT_ADDR, 32'h0);
        apb(1'b0, 8'h04, 32'h0, rdv, err);
        chk("slverr", 32'h1, {31'h0, err});
        nvm_pulse(32'h0000_0008, REG2_RST);
        repeat (100) @(negedge clk);
        chk("busy_noref", 32'h0, {31'h0, busy});
        @(posedge clk);
        ref_ok <= 1'b1;
        cal_cycle(4 * SETTLE - 4, 4 * SETTLE + 16);
        lock_wait(1'b1, 20, 60);
        rd(REG2_ADDR, 32'h0000_00C0);
        rd(STAT_ADDR, 32'h0000_000E);
        for (int w = 0; w < 4; w++) begin
            wr(REG0_ADDR, {17'h0, w[0], w[1], 13'h0008});
            rd(REG0_ADDR, {17'h0, w[0], w[1], 13'h0008});
            fb_skew <= 1'b1;
            lock_wait(1'b0, 0, 16);
            @(posedge clk);
            fb_skew <= 1'b0;
            lock_wait(1'b1, 20, 60);
        end
        wr(REG2_ADDR, 32'h0010_0080);
        repeat (20) @(negedge clk);
        chk("busy_nosel", 32'h0, {31'h0, busy});
        wr(REG2_ADDR, 32'h0000_2080);
        wr(REG2_ADDR, 32'h0010_2080);
        cal_cycle(0, 8);
        lock_wait(1'b1, 20, 60);
        rd(REG2_ADDR, 32'h0010_20C0);
        wr(REG2_ADDR, 32'h0000_0080);
        wr(REG2_ADDR, 32'h0000_0000);
        repeat (50) @(negedge clk);
        chk("out_en_pd", 32'h0, {31'h0, out_en});
        chk("lock_pd", 32'h0, {31'h0, lock});
        wr(REG2_ADDR, 32'h0000_0080);
        cal_cycle(0, 8);
        @(posedge clk);
        pd_pin_n <= 1'b0;
        repeat (10) @(negedge clk);
        chk("out_en_pin", 32'h0, {31'h0, out_en});
        @(posedge clk);
        pd_pin_n <= 1'b1;
        wait_reload();
        nvm_pulse(32'h0000_0008, 32'h0000_2080);
        cal_cycle(0, 10);
        rd(REG2_ADDR, 32'h0000_0080);
        finish_test();
    end
endmodule

bind pllc_ctrl pllc_ctrl_props #(.SETTLE_CYC(SETTLE_CYC)) pllc_ctrl_props_i (
    .REF_CLK_I(REF_CLK_I), .RESETN_I(RESETN_I), .PADDR_I(PADDR_I), .PSEL_I(PSEL_I),
    .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
    .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .IN_DIV_CLK_I(IN_DIV_CLK_I),
    .FB_DIV_CLK_I(FB_DIV_CLK_I), .REF_PRESENT_I(REF_PRESENT_I), .PD_PIN_N_I(PD_PIN_N_I),
    .NVM_DONE_I(NVM_DONE_I), .NVM_REG0_I(NVM_REG0_I), .NVM_REG2_I(NVM_REG2_I),
    .NVM_RELOAD_O(NVM_RELOAD_O), .PLL_LOCK_O(PLL_LOCK_O), .CLK_OUT_EN_O(CLK_OUT_EN_O),
    .CAL_BUSY_O(CAL_BUSY_O));
`default_nettype wire
